// ===== rtl/s213_defs.svh
// Purpose: constants for the 21-to-3 lane serializer
// Assumes: clk runs at seven times the parallel clock in real use
// Notes: the slot order inside a lane is fixed and shared with the receiver
//
// Functional notes
// - All 21 parallel inputs are captured on every rising edge of the parallel clock.
// - Three 7-bit shift registers load in parallel from the captured word and shift out.
// - A bit clock at seven times the word rate unloads one 7-bit slice per word period.
// - Three serial streams and a forwarded clock leave on four differential lanes.
// - The forwarded clock has the same frequency as the word rate.
// - While shutdown is low the slot counter holds at zero and every driver is off.
// - A low shutdown level clears every internal register to zero.
// - Bit k of each lane starts k sevenths of a period after the forwarded clock rises.
`ifndef S213_DEFS_SVH
`define S213_DEFS_SVH
`define S213_DATA_W 21
`define S213_LANES 3
`define S213_SLICE_W 7
`define S213_SLOT_LAST 3'h6
`define S213_FWD_HIGH_SLOTS 3'h4
`define S213_LOCK_WORDS 3'h4
`define S213_PCLK_MIN_MHZ 20
`define S213_PCLK_MAX_MHZ 68
`endif

// ===== rtl/s213_pkg.sv
// Purpose: types for the 21-to-3 lane serializer
// Assumes: nothing beyond the defs header
// Notes: one struct carries the four lane levels
package s213_pkg;
  typedef struct packed {
    logic fwd;
    logic [2:0] lane;
  } s213_line_t;

  typedef enum logic [1:0] {
    S213_OFF = 2'b00,
    S213_LOCKING = 2'b01,
    S213_RUN = 2'b10
  } s213_mode_t;
endpackage

// ===== rtl/s213_serializer.sv
// Purpose: 21-bit parallel to 3 serial lanes plus forwarded clock
// Assumes: clk is the bit clock, seven times the parallel clock
// Notes: words reach the bit domain by a req/ack handshake
`include "s213_defs.svh"

module s213_serializer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic parallel_clock_in,
  input wire logic shutdown_clear_n,
  input wire logic [`S213_DATA_W-1:0] parallel_data,
  output s213_pkg::s213_line_t line_pos,
  output s213_pkg::s213_line_t line_neg,
  output logic driver_en
);
  import s213_pkg::*;

  // Link domain, cleared by reset or shutdown
  logic link_arst_b;
  logic link_rel_s1;
  logic link_rel_s2;
  logic link_rst_b;
  logic ack;
  logic [`S213_DATA_W-1:0] cap;
  logic [`S213_DATA_W-1:0] hold;
  logic req;
  logic ack_s1;
  logic ack_s2;
  logic [`S213_DATA_W-1:0] next_cap;
  logic [`S213_DATA_W-1:0] next_hold;
  logic next_req;

  // Pin level clears at once; release is retimed so no flop sees a runt
  assign link_arst_b = rst_b & shutdown_clear_n;

  always_ff @(posedge parallel_clock_in or negedge link_arst_b) begin
    if (!link_arst_b) begin
      link_rel_s1 <= 1'b0;
      link_rel_s2 <= 1'b0;
    end else begin
      link_rel_s1 <= 1'b1;
      link_rel_s2 <= link_rel_s1;
    end
  end

  assign link_rst_b = link_rel_s2;

  always_comb begin
    next_cap = parallel_data;
    next_hold = hold;
    next_req = req;
    // Only refill hold once the bit side took the last word
    if (req == ack_s2) begin
      next_hold = cap;
      next_req = ~req;
    end
  end

  always_ff @(posedge parallel_clock_in or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cap <= '0;
      hold <= '0;
      req <= 1'b0;
    end else begin
      cap <= next_cap;
      hold <= next_hold;
      req <= next_req;
    end
  end

  // Ack comes back from the bit clock; only ack_s2 is read
  always_ff @(posedge parallel_clock_in or negedge link_rst_b) begin
    if (!link_rst_b) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
    end
  end

  // Bit domain
  logic sd_s1;
  logic sd_s2;
  logic req_s1;
  logic req_s2;
  logic [`S213_DATA_W-1:0] word;
  logic [2:0] slot;
  logic [2:0] lock_cnt;
  s213_mode_t mode;
  logic [`S213_SLICE_W-1:0] shreg [`S213_LANES];
  logic [`S213_SLICE_W-1:0] lane_word [`S213_LANES];
  logic take;
  logic frame_end;
  logic frame_pre;

  logic next_ack;
  logic [`S213_DATA_W-1:0] next_word;
  logic [2:0] next_slot;
  logic [2:0] next_lock_cnt;
  s213_mode_t next_mode;
  logic [`S213_SLICE_W-1:0] next_shreg [`S213_LANES];
  s213_line_t next_line_pos;
  s213_line_t next_line_neg;
  logic next_driver_en;
  logic [2:0] bit_out;

  // Two-flop synchronisers for the pin and the handshake request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_s1 <= 1'b0;
      sd_s2 <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      sd_s1 <= shutdown_clear_n;
      sd_s2 <= sd_s1;
      req_s1 <= req;
      req_s2 <= req_s1;
    end
  end

  assign take = sd_s2 && (req_s2 != ack);
  assign frame_end = (slot == `S213_SLOT_LAST);
  assign frame_pre = (slot == (`S213_SLOT_LAST - 3'h1));

  // Word handshake; hold is stable while req and ack differ
  always_comb begin
    next_ack = ack;
    next_word = word;
    if (!sd_s2) begin
      // Ack back to zero so both sides restart in step
      next_ack = 1'b0;
      next_word = '0;
    end else if (take) begin
      next_ack = ~ack;
      next_word = hold;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
      word <= '0;
    end else begin
      ack <= next_ack;
      word <= next_word;
    end
  end

  // Slot counter; stops while shut down
  always_comb begin
    next_slot = frame_end ? 3'h0 : slot + 3'h1;
    if (!sd_s2) begin
      next_slot = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot <= 3'h0;
    end else begin
      slot <= next_slot;
    end
  end

  // Lock tracking and mode
  always_comb begin
    next_lock_cnt = lock_cnt;
    next_mode = mode;
    if (!sd_s2) begin
      next_lock_cnt = 3'h0;
      next_mode = S213_OFF;
    end else begin
      if (take && lock_cnt != `S213_LOCK_WORDS) begin
        next_lock_cnt = lock_cnt + 3'h1;
      end
      case (mode)
        S213_OFF: begin
          next_mode = S213_LOCKING;
        end
        S213_LOCKING: begin
          // Word arrivals stand in for lock; one slot early so frame one is whole
          if (lock_cnt == `S213_LOCK_WORDS && frame_pre) begin
            next_mode = S213_RUN;
          end
        end
        S213_RUN: begin
          next_mode = S213_RUN;
        end
        default: begin
          next_mode = S213_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt <= 3'h0;
      mode <= S213_OFF;
    end else begin
      lock_cnt <= next_lock_cnt;
      mode <= next_mode;
    end
  end

  // Output legs; both legs low while the drivers are off
  always_comb begin
    next_line_pos = '0;
    next_line_neg = '0;
    next_driver_en = 1'b0;
    if (sd_s2 && mode == S213_RUN) begin
      next_line_pos.lane = bit_out;
      next_line_pos.fwd = (next_slot < `S213_FWD_HIGH_SLOTS);
      next_line_neg = ~next_line_pos;
      next_driver_en = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_pos <= '0;
      line_neg <= '0;
      driver_en <= 1'b0;
    end else begin
      line_pos <= next_line_pos;
      line_neg <= next_line_neg;
      driver_en <= next_driver_en;
    end
  end

  // Per-lane shifter; slot 6 reloads and puts the new bit 0 out at once
  genvar gi;
  generate
    for (gi = 0; gi < `S213_LANES; gi++) begin : g_lane
      assign lane_word[gi] = word[gi*`S213_SLICE_W +: `S213_SLICE_W];
      assign next_shreg[gi] = frame_end ? lane_word[gi] : (shreg[gi] >> 1);
      assign bit_out[gi] = frame_end ? lane_word[gi][0] : shreg[gi][1];
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          shreg[gi] <= '0;
        end else if (!sd_s2) begin
          shreg[gi] <= '0;
        end else begin
          shreg[gi] <= next_shreg[gi];
        end
      end
    end
  endgenerate
endmodule

// ===== verification/s213_serializer_chk.sv
// Purpose: port checks; Assumes: bound to top; Notes: 5 clk sync slack
module s213_serializer_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic shutdown_clear_n,
  input wire s213_pkg::s213_line_t line_pos,
  input wire s213_pkg::s213_line_t line_neg,
  input wire logic driver_en
);
  timeunit 1ns;
  timeprecision 1ps;
  import s213_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_comp; driver_en |-> line_neg == ~line_pos; endproperty
  a_comp: assert property (p_comp) else $error("legs");
  property p_off; !driver_en |-> {line_pos, line_neg} == 8'h00; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_fall; $fell(shutdown_clear_n) |-> ##[1:5] !driver_en; endproperty
  a_fall: assert property (p_fall) else $error("fall");
  property p_held; !shutdown_clear_n [*6] |-> line_pos == 4'h0; endproperty
  a_held: assert property (p_held) else $error("held");
  property p_per; $rose(line_pos.fwd) |-> ##3 (line_pos.fwd || !driver_en)
    ##1 !line_pos.fwd ##3 (line_pos.fwd || !driver_en); endproperty
  a_per: assert property (p_per) else $error("period");
  property p_gap; $rose(line_pos.fwd) |-> !$past(line_pos.fwd, 2); endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_lock; $rose(driver_en) |-> line_pos.fwd && $past(shutdown_clear_n, 8); endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_drop; $fell(driver_en) |-> !shutdown_clear_n; endproperty
  a_drop: assert property (p_drop) else $error("drop");
  c_on: cover property ($rose(driver_en));
  c_dn: cover property ($fell(driver_en));
  c_fw: cover property ($rose(line_pos.fwd));
endmodule
bind s213_serializer s213_serializer_chk u_s213_serializer_chk (.clk(clk), .rst_b(rst_b),
  .shutdown_clear_n(shutdown_clear_n), .line_pos(line_pos), .line_neg(line_neg),
  .driver_en(driver_en));

// ===== verification/s213_rx_model.sv
// Purpose: receiver; Assumes: fwd rise is slot 0; Notes: no lock check
module s213_rx_model (
  input wire logic clk,
  input wire s213_pkg::s213_line_t line_pos,
  input wire logic driver_en,
  output logic [20:0] word,
  output int unsigned count
);
  timeunit 1ns;
  timeprecision 1ps;
  import s213_pkg::*;
  int k = 0;
  logic pf = 1'b0;
  logic [20:0] w = 21'h0;
  initial begin
    word = 21'h0;
    count = 0;
  end
  always @(posedge clk) begin
    k = (line_pos.fwd && !pf) ? 0 : k + 1;
    pf = line_pos.fwd;
    for (int i = 0; i < 3; i++) if (k < 7) w[7 * i + k] = line_pos.lane[i];
    if (driver_en && k == 6) begin
      word <= w;
      count <= count + 1;
    end
  end
endmodule

// ===== verification/tb_s213_serializer.sv
// Purpose: bench; Assumes: clk stands for the bit clock; Notes: early words dropped
module tb_s213_serializer;
  timeunit 1ns;
  timeprecision 1ps;
  import s213_pkg::*;
  logic clk, rst_b, parallel_clock_in, shutdown_clear_n, driver_en;
  logic [20:0] parallel_data, word;
  s213_line_t line_pos, line_neg;
  int unsigned count;
  int err_count, checks;
  logic [20:0] pats [4] = '{21'h000001, 21'h100000, 21'h15555A, 21'h1FFFFF};
  s213_serializer u_s213_serializer (.clk(clk), .rst_b(rst_b),
    .parallel_clock_in(parallel_clock_in), .shutdown_clear_n(shutdown_clear_n),
    .parallel_data(parallel_data), .line_pos(line_pos), .line_neg(line_neg),
    .driver_en(driver_en));
  s213_rx_model u_s213_rx_model (.clk(clk), .line_pos(line_pos), .driver_en(driver_en),
    .word(word), .count(count));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    parallel_clock_in = 0;
    #7;
    forever #24 parallel_clock_in = ~parallel_clock_in;
  end
  task close_out;
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [20:0] got, input logic [20:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wait_on;
    for (int i = 0; i < 300 && driver_en !== 1'b1; i++) @(posedge clk);
    chk(driver_en, 21'h1);
  endtask
  // Four words so stale ones in flight drain first
  task send(input logic [20:0] d);
    int unsigned c;
    @(posedge clk) parallel_data <= d;
    c = count;
    for (int i = 0; i < 300 && count < c + 4; i++) @(posedge clk);
    chk(word, d);
  endtask
  task shut_test;
    @(posedge clk) shutdown_clear_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({12'h0, line_pos, line_neg, driver_en}, 21'h0);
    @(posedge clk) shutdown_clear_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(driver_en, 21'h0);
    wait_on;
    send(21'h0ABCDE);
  endtask
  task rst_test;
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({12'h0, line_pos, line_neg, driver_en}, 21'h0);
    repeat (14) @(posedge clk);
    rst_b <= 1'b1;
    wait_on;
    send(21'h13579B);
  endtask
  initial begin
    rst_b = 0;
    shutdown_clear_n = 1;
    parallel_data = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    wait_on;
    foreach (pats[i]) send(pats[i]);
    shut_test;
    rst_test;
    close_out;
  end
  initial begin
    #500000;
    err_count++;
    close_out;
  end
endmodule
